/* File: verilog/bdft_fifo.sv */
`timescale 1ns/1ps

package bdft_pkg;
    localparam int          BDFT_WIDTH     = 9;
    localparam int          BDFT_DEPTH     = 32;
    localparam int          BDFT_LIM_W     = 6;
    localparam int          BDFT_DEF_BITS  = 5;
    localparam int          BDFT_SYNC_LEN  = 3;
    localparam logic [5:0]  BDFT_DEPTH_RST = 6'h20;
    localparam logic [4:0]  BDFT_X_RST     = 5'h00;
    localparam logic [8:0]  BDFT_DATA_RST  = 9'h000;

    // one side's pins, after filtering
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       def;
        logic       rst_n;
        logic       sel;
        logic       en;
        logic [8:0] data;
    } bdft_pins_t;
endpackage : bdft_pkg

module bdft_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_i,
    // control
    input  wire logic                       clear_i,
    input  wire logic [$clog2(DEPTH):0]     limit_i,
    // fill side
    input  wire logic                       wr_valid_i,
    output logic                            wr_ready_o,
    input  wire logic [WIDTH-1:0]           wr_data_i,
    // drain side
    output logic                            rd_valid_o,
    input  wire logic                       rd_ready_i,
    output logic [WIDTH-1:0]                rd_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [CW-1:0]    count_q;
    logic             push_w;
    logic             pop_w;
    logic [AW-1:0]    wptr_nx_w;
    logic [AW-1:0]    rptr_nx_w;

    assign wr_ready_o = ~clear_i & (count_q != limit_i);
    assign rd_valid_o = ~clear_i & (count_q != '0);
    assign push_w     = wr_valid_i & wr_ready_o;
    assign pop_w      = rd_ready_i & rd_valid_o;
    assign wptr_nx_w  = (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
    assign rptr_nx_w  = (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
    assign rd_data_o  = mem_q[rptr_q];

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else if (clear_i) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else begin
            wptr_q  <= push_w ? wptr_nx_w : wptr_q;
            rptr_q  <= pop_w ? rptr_nx_w : rptr_q;
            count_q <= count_q + CW'(push_w) - CW'(pop_w);
        end
    end

    // storage needs no reset: contents are unspecified until loaded
    for (genvar i = 0; i < DEPTH; i++) begin : g_mem
        always_ff @(posedge clk_sys_i) begin
            if (push_w && wptr_q == AW'(i)) begin
                mem_q[i] <= wr_data_i;
            end
        end
    end

    property p_full_blocks;
        @(posedge clk_sys_i) disable iff (rst_i)
        (count_q == limit_i && wr_valid_i && !rd_ready_i && !clear_i) |=> (count_q == $past(count_q)) && $stable(wptr_q);
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("load accepted while full");

    property p_empty_blocks;
        @(posedge clk_sys_i) disable iff (rst_i)
        (count_q == '0 && rd_ready_i && !wr_valid_i && !clear_i) |=> (count_q == '0) && $stable(rptr_q);
    endproperty
    a_empty_blocks: assert property (p_empty_blocks) else $error("unload accepted while empty");

    property p_push_counts;
        @(posedge clk_sys_i) disable iff (rst_i)
        (push_w && !pop_w) |=> count_q == $past(count_q) + 1'b1;
    endproperty
    a_push_counts: assert property (p_push_counts) else $error("load did not add one word");

    property p_pop_advances;
        @(posedge clk_sys_i) disable iff (rst_i)
        (pop_w && !push_w) |=> (rptr_q == $past(rptr_nx_w)) && (count_q == $past(count_q) - 1'b1);
    endproperty
    a_pop_advances: assert property (p_pop_advances) else $error("unload did not advance");

    property p_clear_empties;
        @(posedge clk_sys_i) disable iff (rst_i)
        clear_i |=> (count_q == '0) && (wptr_q == '0) && (rptr_q == '0);
    endproperty
    a_clear_empties: assert property (p_clear_empties) else $error("reset pulse left pointers");
endmodule : bdft_fifo

/* File: verilog/bdft_top.sv */
`timescale 1ns/1ps

module bdft_top (
    // clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_i,
    // bus A
    input  wire logic [8:0]                 a_bus_i,
    output logic [8:0]                      a_bus_o,
    output logic                            a_bus_oe_o,
    // bus B
    input  wire logic [8:0]                 b_bus_i,
    output logic [8:0]                      b_bus_o,
    output logic                            b_bus_oe_o,
    // strobes
    input  wire logic                       a_side_write_strobe_i,
    input  wire logic                       b_side_write_strobe_i,
    input  wire logic                       a_queue_read_strobe_i,
    input  wire logic                       b_queue_read_strobe_i,
    // depth programming and queue resets
    input  wire logic                       a_depth_define_i,
    input  wire logic                       b_depth_define_i,
    input  wire logic                       a_queue_reset_n_i,
    input  wire logic                       b_queue_reset_n_i,
    // bus steering
    input  wire logic                       a_bus_source_select_i,
    input  wire logic                       b_bus_source_select_i,
    input  wire logic                       a_bus_drive_enable_i,
    input  wire logic                       b_bus_drive_enable_i,
    // status flags
    output logic                            a_queue_full_n_o,
    output logic                            b_queue_full_n_o,
    output logic                            a_queue_empty_n_o,
    output logic                            b_queue_empty_n_o
);
    localparam int PW = $bits(bdft_pkg::bdft_pins_t);
    localparam int NB = 2 * PW;

    logic [NB-1:0]               raw_w;
    logic [NB-1:0]               s1_q;
    logic [NB-1:0]               s2_q;
    logic [NB-1:0]               s3_q;
    logic [NB-1:0]               stab_q;
    logic [NB-1:0]               prev_q;
    bdft_pkg::bdft_pins_t        cur_w    [2];
    bdft_pkg::bdft_pins_t        prv_w    [2];
    logic [4:0]                  x_q      [2];
    logic [5:0]                  depth_q  [2];
    logic [8:0]                  out_q    [2];
    logic [8:0]                  bus_q    [2];
    logic                        oe_q     [2];
    logic                        full_n_w [2];
    logic                        empty_n_w[2];

    assign raw_w = {b_side_write_strobe_i, b_queue_read_strobe_i, b_depth_define_i, b_queue_reset_n_i,
                    b_bus_source_select_i, b_bus_drive_enable_i, b_bus_i,
                    a_side_write_strobe_i, a_queue_read_strobe_i, a_depth_define_i, a_queue_reset_n_i,
                    a_bus_source_select_i, a_bus_drive_enable_i, a_bus_i};

    // every pin is asynchronous to clk_sys_i; data shares the control latency
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            prev_q <= '0;
        end else begin
            s1_q   <= raw_w;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            prev_q <= stab_q;
        end
    end

    for (genvar i = 0; i < NB; i++) begin : g_filt
        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                stab_q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                stab_q[i] <= s3_q[i];
            end
        end
    end

    for (genvar q = 0; q < 2; q++) begin : g_queue
        localparam int OPP = 1 - q;
        logic       wr_edge_w;
        logic       rd_edge_w;
        logic       def_fall_w;
        logic       rst_rise_w;
        logic       clear_w;
        logic       head_ok_w;
        logic [8:0] head_w;
        logic [5:0] prog_w;
        logic [8:0] mux_w;

        assign cur_w[q]   = stab_q[q*PW +: PW];
        assign prv_w[q]   = prev_q[q*PW +: PW];
        assign wr_edge_w  = cur_w[q].wr & ~prv_w[q].wr;
        assign rd_edge_w  = cur_w[q].rd & ~prv_w[q].rd;
        assign def_fall_w = ~cur_w[q].def & prv_w[q].def;
        assign rst_rise_w = cur_w[q].rst_n & ~prv_w[q].rst_n;
        assign clear_w    = ~cur_w[q].rst_n;
        assign prog_w     = cur_w[q].def ? bdft_pkg::BDFT_DEPTH_RST
                                         : bdft_pkg::BDFT_DEPTH_RST - {1'b0, x_q[q]};
        // stored word for bus q comes from the opposite queue
        assign mux_w      = cur_w[q].sel ? out_q[OPP] : cur_w[OPP].data;

        bdft_fifo #(
            .WIDTH (bdft_pkg::BDFT_WIDTH),
            .DEPTH (bdft_pkg::BDFT_DEPTH)
        ) u_fifo (
            .clk_sys_i  (clk_sys_i),
            .rst_i      (rst_i),
            .clear_i    (clear_w),
            .limit_i    (depth_q[q]),
            .wr_valid_i (wr_edge_w),
            .wr_ready_o (full_n_w[q]),
            .wr_data_i  (cur_w[q].data),
            .rd_valid_o (head_ok_w),
            .rd_ready_i (rd_edge_w),
            .rd_data_o  (head_w)
        );

        assign empty_n_w[q] = head_ok_w;

        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                x_q[q]     <= bdft_pkg::BDFT_X_RST;
                depth_q[q] <= bdft_pkg::BDFT_DEPTH_RST;
            end else begin
                x_q[q]     <= def_fall_w ? cur_w[q].data[bdft_pkg::BDFT_DEF_BITS-1:0] : x_q[q];
                depth_q[q] <= rst_rise_w ? prog_w : depth_q[q];
            end
        end

        // last valid word stays when the queue runs empty
        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                out_q[q] <= bdft_pkg::BDFT_DATA_RST;
                bus_q[q] <= bdft_pkg::BDFT_DATA_RST;
                oe_q[q]  <= 1'b0;
            end else begin
                out_q[q] <= head_ok_w ? head_w : out_q[q];
                bus_q[q] <= mux_w;
                oe_q[q]  <= cur_w[q].en;
            end
        end

        property p_depth_prog;
            @(posedge clk_sys_i) disable iff (rst_i)
            (rst_rise_w && !cur_w[q].def) |=> depth_q[q] == bdft_pkg::BDFT_DEPTH_RST - {1'b0, $past(x_q[q])};
        endproperty
        a_depth_prog: assert property (p_depth_prog) else $error("depth not set to 32 minus X");

        property p_depth_full;
            @(posedge clk_sys_i) disable iff (rst_i)
            (rst_rise_w && cur_w[q].def) |=> depth_q[q] == bdft_pkg::BDFT_DEPTH_RST;
        endproperty
        a_depth_full: assert property (p_depth_full) else $error("depth not set to 32");

        property p_drive_follows;
            @(posedge clk_sys_i) disable iff (rst_i)
            ##1 (oe_q[q] == $past(cur_w[q].en));
        endproperty
        a_drive_follows: assert property (p_drive_follows) else $error("bus drive not following enable");

        property p_stored_route;
            @(posedge clk_sys_i) disable iff (rst_i)
            cur_w[q].sel |=> bus_q[q] == $past(out_q[OPP]);
        endproperty
        a_stored_route: assert property (p_stored_route) else $error("stored word not on bus");

        property p_live_route;
            @(posedge clk_sys_i) disable iff (rst_i)
            !cur_w[q].sel |=> bus_q[q] == $past(cur_w[OPP].data);
        endproperty
        a_live_route: assert property (p_live_route) else $error("live word not on bus");

        property p_no_glitch;
            @(posedge clk_sys_i) disable iff (rst_i)
            $changed(cur_w[q].sel) |=> (bus_q[q] == $past(out_q[OPP])) || (bus_q[q] == $past(cur_w[OPP].data));
        endproperty
        a_no_glitch: assert property (p_no_glitch) else $error("bus took a third value on select change");

        property p_reset_flags;
            @(posedge clk_sys_i) disable iff (rst_i)
            clear_w |-> (!empty_n_w[q] && !full_n_w[q]) ##1 (!empty_n_w[q] && (full_n_w[q] || clear_w));
        endproperty
        a_reset_flags: assert property (p_reset_flags) else $error("flags wrong during reset pulse");

        property p_flags_consistent;
            @(posedge clk_sys_i) disable iff (rst_i)
            (!clear_w && depth_q[q] != '0) |-> (full_n_w[q] || empty_n_w[q]);
        endproperty
        a_flags_consistent: assert property (p_flags_consistent) else $error("queue full and empty at once");
    end

    // full_n is forced low by the fifo while cleared, the full_n outputs show high outside
    assign a_queue_full_n_o  = full_n_w[0] | ~cur_w[0].rst_n;
    assign b_queue_full_n_o  = full_n_w[1] | ~cur_w[1].rst_n;
    assign a_queue_empty_n_o = empty_n_w[0];
    assign b_queue_empty_n_o = empty_n_w[1];
    assign a_bus_o           = bus_q[0];
    assign b_bus_o           = bus_q[1];
    assign a_bus_oe_o        = oe_q[0];
    assign b_bus_oe_o        = oe_q[1];
endmodule : bdft_top

/* File: tb/bdft_bus_master.sv */
`timescale 1ns/1ps

module bdft_bus_master (
    // master side
    input  wire logic       drive_i,
    input  wire logic [8:0] word_i,
    // device side of the same bus
    input  wire logic       dev_oe_i,
    input  wire logic [8:0] dev_word_i,
    // resolved bus level
    output logic [8:0]      wire_o
);
    // a released bus flips, so a stale word never reads back by luck
    logic [8:0] level = 9'h000;

    assign wire_o = level;

    always @(drive_i or word_i or dev_oe_i or dev_word_i) begin
        if (dev_oe_i)
            level = dev_word_i;
        else if (drive_i)
            level = word_i;
        else
            level = ~level;
    end
endmodule : bdft_bus_master

/* File: tb/bdft_top_bench.sv */
`timescale 1ns/1ps

module bdft_top_bench;
    logic       clk_sys_i, rst_i, a_ws, b_ws, a_rs, b_rs, a_def, b_def, a_rn, b_rn;
    logic       a_sel, b_sel, a_en, b_en, a_drv, b_drv, a_oe, b_oe;
    logic       a_full_n, b_full_n, a_empty_n, b_empty_n;
    logic [8:0] a_word, b_word, a_wire, b_wire, a_out, b_out;
    int         error_cnt, check_count;
    wire  [3:0] flags = {b_empty_n, a_empty_n, b_full_n, a_full_n};

    bdft_bus_master a_mst_u (.drive_i(a_drv), .word_i(a_word), .dev_oe_i(a_oe), .dev_word_i(a_out), .wire_o(a_wire));
    bdft_bus_master b_mst_u (.drive_i(b_drv), .word_i(b_word), .dev_oe_i(b_oe), .dev_word_i(b_out), .wire_o(b_wire));

    bdft_top dut_u (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .a_bus_i(a_wire), .a_bus_o(a_out), .a_bus_oe_o(a_oe),
        .b_bus_i(b_wire), .b_bus_o(b_out), .b_bus_oe_o(b_oe),
        .a_side_write_strobe_i(a_ws), .b_side_write_strobe_i(b_ws),
        .a_queue_read_strobe_i(a_rs), .b_queue_read_strobe_i(b_rs),
        .a_depth_define_i(a_def), .b_depth_define_i(b_def),
        .a_queue_reset_n_i(a_rn), .b_queue_reset_n_i(b_rn),
        .a_bus_source_select_i(a_sel), .b_bus_source_select_i(b_sel),
        .a_bus_drive_enable_i(a_en), .b_bus_drive_enable_i(b_en),
        .a_queue_full_n_o(a_full_n), .b_queue_full_n_o(b_full_n),
        .a_queue_empty_n_o(a_empty_n), .b_queue_empty_n_o(b_empty_n)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : tick

    task automatic conclude;
        if (error_cnt == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic check(input string nm, input logic [8:0] exp, input logic [8:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // flags pass the pin filter, so allow a bounded settling time
    task automatic wait_flag(input string nm, input int idx, input logic exp);
        logic v;
        for (int i = 0; i < 20; i++) begin
            v = flags[idx];
            if (v === exp)
                break;
            tick(1);
        end
        check(nm, {8'h00, exp}, {8'h00, v});
        if (v !== exp)
            conclude();
    endtask : wait_flag

    // word held from 4 clocks before the edge until the next call
    task automatic strobe(input bit q, input bit rd, input logic [8:0] w);
        if (!rd && q)
            b_word = w;
        if (!rd && !q)
            a_word = w;
        tick(4);
        {a_ws, b_ws, a_rs, b_rs} = {!rd && !q, !rd && q, rd && !q, rd && q};
        tick(4);
        {a_ws, b_ws, a_rs, b_rs} = 4'h0;
        tick(6);
    endtask : strobe

    task automatic program_depth(input bit q, input bit def_lvl, input logic [4:0] x);
        {a_def, b_def} = 2'h3;
        if (q)
            b_word = {4'h0, x};
        else
            a_word = {4'h0, x};
        // device may still drive the bus for a few clocks after its enable drops
        tick(8);
        {a_def, b_def} = {q, !q};
        tick(4);
        {a_def, b_def} = {q || def_lvl, !q || def_lvl};
        {a_rn, b_rn} = {q, !q};
        tick(5);
        {a_rn, b_rn} = 2'h3;
        tick(6);
    endtask : program_depth

    initial begin
        {rst_i, a_ws, b_ws, a_rs, b_rs, a_rn, b_rn, a_en, b_drv} = 9'h100;
        {a_def, b_def, a_sel, b_sel, b_en, a_drv} = 6'h3f;
        a_word = 9'h000;
        b_word = 9'h000;
        error_cnt = 0;
        check_count = 0;
        tick(16);
        rst_i = 1'b0;
        {a_rn, b_rn} = 2'h3;
        tick(6);
        wait_flag("a_queue_empty_n_o", 2, 1'b0);
        wait_flag("a_queue_full_n_o", 0, 1'b1);
        strobe(0, 0, 9'h1a5);
        strobe(0, 0, 9'h05a);
        strobe(0, 0, 9'h100);
        wait_flag("a_queue_empty_n_o", 2, 1'b1);
        wait_flag("b_queue_empty_n_o", 3, 1'b0);
        check("b_bus_o", 9'h1a5, b_out);
        check("b_bus_oe_o", 9'h001, {8'h00, b_oe});
        strobe(0, 1, 9'h000);
        check("b_bus_o", 9'h05a, b_out);
        strobe(0, 1, 9'h000);
        strobe(0, 1, 9'h000);
        wait_flag("a_queue_empty_n_o", 2, 1'b0);
        strobe(0, 1, 9'h000);
        check("b_bus_o", 9'h100, b_out);
        strobe(0, 0, 9'h0f0);
        check("b_bus_o", 9'h0f0, b_out);
        {b_en, a_drv, a_en, b_drv} = 4'h3;
        tick(6);
        check("b_bus_oe_o", 9'h000, {8'h00, b_oe});
        check("a_bus_oe_o", 9'h001, {8'h00, a_oe});
        for (int i = 0; i < 32; i++)
            strobe(1, 0, 9'(i * 5 + 3));
        wait_flag("b_queue_full_n_o", 1, 1'b0);
        strobe(1, 0, 9'h1ff);
        for (int i = 0; i < 32; i++) begin
            check("a_bus_o", 9'(i * 5 + 3), a_out);
            strobe(1, 1, 9'h000);
        end
        wait_flag("b_queue_empty_n_o", 3, 1'b0);
        check("a_bus_o", 9'h09e, a_out);
        {a_en, a_drv} = 2'h1;
        program_depth(0, 0, 5'h1e);
        wait_flag("a_queue_empty_n_o", 2, 1'b0);
        strobe(0, 0, 9'h011);
        strobe(0, 0, 9'h022);
        wait_flag("a_queue_full_n_o", 0, 1'b0);
        strobe(0, 0, 9'h033);
        strobe(0, 1, 9'h000);
        check("b_bus_o", 9'h022, b_out);
        wait_flag("a_queue_full_n_o", 0, 1'b1);
        strobe(0, 1, 9'h000);
        wait_flag("a_queue_empty_n_o", 2, 1'b0);
        program_depth(0, 1, 5'h1e);
        for (int i = 0; i < 3; i++)
            strobe(0, 0, 9'(i));
        wait_flag("a_queue_full_n_o", 0, 1'b1);
        a_rn = 1'b0;
        tick(5);
        wait_flag("a_queue_empty_n_o", 2, 1'b0);
        wait_flag("a_queue_full_n_o", 0, 1'b1);
        a_rn = 1'b1;
        {b_sel, b_en} = 2'h1;
        a_word = 9'h0c3;
        tick(8);
        check("b_bus_o", 9'h0c3, b_out);
        a_word = 9'h13c;
        tick(8);
        check("b_bus_o", 9'h13c, b_out);
        {b_en, b_drv, a_drv, a_en, a_sel} = 5'h0a;
        b_word = 9'h155;
        // bus b turnaround takes five clocks before the filter even sees the word
        tick(12);
        check("a_bus_o", 9'h155, a_out);
        a_sel = 1'b1;
        tick(8);
        check("a_bus_o", 9'h09e, a_out);
        conclude();
    end
endmodule : bdft_top_bench
